// ===== la_framer.v
// Look-aside control word framer: field mapping, in-band status, bursts
//
// Behaviour
// - Receive channel bit zero shows packet channel
// - Transmit channel bit zero selects sending channel
// - Field two: word 31:24 to bus 8:1
// - Field one: word 38:33 to bus 14:9
// - Field zero: word 56:42 to bus 29:15
// - Receive extracts all three fields onto bus
// - Transmit inserts all three fields into words
// - Transmit status bits go to word 40,41
// - Receive status taken from word 40,41
// - Burst-short zero 8 bytes, one 16 bytes
// - Transmit accepts up to four bursts per cycle
// - No multiple-use bit signals provided
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "la_framer_consts.vh"
module la_framer
#(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
)
(
    input wire sys_clk,
    input wire rst_n,
    // Wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // User transmit side
    input wire tx_valid,
    output reg tx_ready,
    input wire [29:0] tx_chanin,
    input wire [1:0] tx_burst_num,
    input wire [7:0] tx_burst_bytes,
    input wire [1:0] tx_inband_xon_status,
    // Link transmit side
    output reg link_tx_valid,
    input wire link_tx_ready,
    output reg [63:0] link_tx_cw,
    output reg [7:0] link_tx_bytes,
    // Link receive side
    input wire link_rx_valid,
    input wire [63:0] link_rx_cw,
    // User receive side
    output reg rx_valid,
    output reg [29:0] rx_chanout,
    output reg [1:0] rx_inband_xon_status
);

// No multiple-use bit ports exist in this mode

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
localparam ENTRY_W = 40; // Channel bus, burst count, byte length
localparam ST_IDLE = 2'b01; // Waiting for a FIFO entry
localparam ST_SEND = 2'b10; // Emitting control words of an entry

reg [2:0] bshort_reg; // Software burst-short setting
reg [2:0] bshort_next;
reg [2:0] bshort_act_reg; // Copy in use by the serializer
reg badcfg_reg; // Sticky: reserved setting was written
reg badcfg_next;
reg [31:0] tx_count_reg; // Control words sent
reg [31:0] rx_count_reg; // Control words received
reg [1:0] state_reg; // Serializer state
reg [1:0] state_next;
reg [29:0] hold_chan_reg; // Channel bus of entry being sent
reg [29:0] hold_chan_next;
reg [1:0] left_reg; // Bursts of the entry still to send after the current one
reg [1:0] left_next;
reg [7:0] hold_bytes_reg; // Padded burst length of the entry
reg [7:0] hold_bytes_next;
reg link_valid_next;
reg [63:0] link_cw_next;
reg [7:0] link_bytes_next;
reg fifo_pop;
reg [31:0] rd_data;
reg [7:0] min_bytes;
wire wb_req;
wire wb_wr;
wire fifo_in_ready;
wire fifo_out_valid;
wire [ENTRY_W-1:0] fifo_out_data;
wire [FIFO_AW:0] fifo_level;
wire tx_push;
wire out_free;
wire [FIFO_AW+1:0] level_after;
wire [ENTRY_W-1:0] tx_entry;
wire [2:0] wr_bshort;
wire bshort_ok;

// ----------------------------------------------------------------
// Wishbone decode
// ----------------------------------------------------------------
// A request is answered once; ack drops in the following cycle
assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
assign wb_wr = wb_req && wb_we_i;
assign wr_bshort = wb_dat_i[`CFG_BSHORT_MSB:`CFG_BSHORT_LSB];
assign bshort_ok = (wr_bshort == `BSHORT_8) ||
                   (wr_bshort == `BSHORT_16);

// Ack generator, one wait-free cycle after the strobe
always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        wb_ack_o <= 1'b0;
    end
    else
    begin
        wb_ack_o <= wb_req;
    end
end

// Config and sticky error next state
always @*
begin
    bshort_next = bshort_reg;
    badcfg_next = badcfg_reg;
    // Write one to clear the sticky error flag
    if (wb_wr && wb_adr_i == `OFS_STATUS && wb_sel_i[0] &&
        wb_dat_i[`STS_BADCFG_BIT])
    begin
        badcfg_next = 1'b0;
    end
    if (wb_wr && wb_adr_i == `OFS_CONFIG && wb_sel_i[0])
    begin
        if (bshort_ok)
        begin
            bshort_next = wr_bshort;
        end
        else
        begin
            // Reserved value kept out; flag set wins over clear
            badcfg_next = 1'b1;
        end
    end
end

// Config registers
always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        bshort_reg <= `CFG_BSHORT_RST;
        badcfg_reg <= 1'b0;
    end
    else
    begin
        bshort_reg <= bshort_next;
        badcfg_reg <= badcfg_next;
    end
end

// Read mux; unmapped offsets read as zero
always @*
begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
        `OFS_CONFIG:
        begin
            rd_data[`CFG_BSHORT_MSB:`CFG_BSHORT_LSB] = bshort_reg;
        end
        `OFS_STATUS:
        begin
            rd_data[`STS_XON_MSB:`STS_XON_LSB] = rx_inband_xon_status;
            rd_data[`STS_BADCFG_BIT] = badcfg_reg;
            rd_data[`STS_LEVEL_MSB:`STS_LEVEL_LSB] = fifo_level;
            rd_data[`STS_BUSY_BIT] = state_reg[1];
        end
        `OFS_TX_COUNT:
        begin
            rd_data = tx_count_reg;
        end
        `OFS_RX_COUNT:
        begin
            rd_data = rx_count_reg;
        end
        default:
        begin
            rd_data = 32'h0000_0000;
        end
    endcase
end

// Read data register, loaded with the answer
always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        wb_dat_o <= 32'h0000_0000;
    end
    else if (wb_req && !wb_we_i)
    begin
        wb_dat_o <= rd_data;
    end
end

// ----------------------------------------------------------------
// Transmit intake
// ----------------------------------------------------------------
// One entry carries up to four bursts, taken in a single cycle
assign tx_entry = {tx_burst_bytes, tx_burst_num, tx_chanin};
assign tx_push = tx_valid && tx_ready && fifo_in_ready;
assign level_after = {1'b0, fifo_level} +
                     {{(FIFO_AW+1){1'b0}}, tx_push} -
                     {{(FIFO_AW+1){1'b0}}, fifo_pop};

// Ready is registered from the level the FIFO will hold next cycle
always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        tx_ready <= 1'b0;
    end
    else
    begin
        tx_ready <= (level_after < FIFO_DEPTH);
    end
end

burst_fifo
#(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
)
u_fifo
(
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(tx_push),
    .in_ready(fifo_in_ready),
    .in_data(tx_entry),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
);

// ----------------------------------------------------------------
// Transmit serializer
// ----------------------------------------------------------------
assign out_free = !link_tx_valid || link_tx_ready;

// Minimum burst size from the active setting
always @*
begin
    case (bshort_act_reg)
        `BSHORT_16:
        begin
            min_bytes = `MIN_BYTES_16;
        end
        default:
        begin
            min_bytes = `MIN_BYTES_8;
        end
    endcase
end

// Control word for one burst of the given entry
function [63:0] build_cw;
    input [29:0] chan;
    input [1:0] xon;
    begin
        build_cw = 64'h0000_0000_0000_0000;
        build_cw[`CW_MARK_BIT] = 1'b1;
        build_cw[`CW_CHAN_BIT] = chan[`CB_CHAN_BIT];
        build_cw[`CW_AS2_MSB:`CW_AS2_LSB] =
            chan[`CB_AS2_MSB:`CB_AS2_LSB];
        build_cw[`CW_AS1_MSB:`CW_AS1_LSB] =
            chan[`CB_AS1_MSB:`CB_AS1_LSB];
        build_cw[`CW_AS0_MSB:`CW_AS0_LSB] =
            chan[`CB_AS0_MSB:`CB_AS0_LSB];
        build_cw[`CW_XON0_BIT] = xon[0];
        build_cw[`CW_XON1_BIT] = xon[1];
    end
endfunction

// Serializer next state; status is sampled per word to stay fresh
always @*
begin
    state_next = state_reg;
    hold_chan_next = hold_chan_reg;
    left_next = left_reg;
    hold_bytes_next = hold_bytes_reg;
    link_valid_next = link_tx_valid;
    link_cw_next = link_tx_cw;
    link_bytes_next = link_tx_bytes;
    fifo_pop = 1'b0;
    if (out_free)
    begin
        link_valid_next = 1'b0;
    end
    case (state_reg)
        ST_IDLE:
        begin
            if (out_free && fifo_out_valid)
            begin
                // First burst goes out in the same step as the pop
                fifo_pop = 1'b1;
                hold_chan_next = fifo_out_data[29:0];
                left_next = fifo_out_data[31:30];
                if (fifo_out_data[39:32] < min_bytes)
                begin
                    hold_bytes_next = min_bytes;
                end
                else
                begin
                    hold_bytes_next = fifo_out_data[39:32];
                end
                link_valid_next = 1'b1;
                link_cw_next = build_cw(fifo_out_data[29:0],
                                        tx_inband_xon_status);
                link_bytes_next = hold_bytes_next;
                if (fifo_out_data[31:30] != 2'h0)
                begin
                    state_next = ST_SEND;
                end
            end
        end
        ST_SEND:
        begin
            if (out_free)
            begin
                // Remaining bursts of the entry, one per cycle
                left_next = left_reg - 2'h1;
                link_valid_next = 1'b1;
                link_cw_next = build_cw(hold_chan_reg,
                                        tx_inband_xon_status);
                link_bytes_next = hold_bytes_reg;
                if (left_reg == 2'h1)
                begin
                    state_next = ST_IDLE;
                end
            end
        end
        default:
        begin
            state_next = ST_IDLE;
        end
    endcase
end

// Serializer registers
always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        state_reg <= ST_IDLE;
        hold_chan_reg <= 30'h0000_0000;
        left_reg <= 2'h0;
        hold_bytes_reg <= 8'h00;
        link_tx_valid <= 1'b0;
        link_tx_cw <= 64'h0000_0000_0000_0000;
        link_tx_bytes <= 8'h00;
        bshort_act_reg <= `CFG_BSHORT_RST;
    end
    else
    begin
        state_reg <= state_next;
        hold_chan_reg <= hold_chan_next;
        left_reg <= left_next;
        hold_bytes_reg <= hold_bytes_next;
        link_tx_valid <= link_valid_next;
        link_tx_cw <= link_cw_next;
        link_tx_bytes <= link_bytes_next;
        // Setting is static; a late change waits for an idle gap
        if (state_reg == ST_IDLE && !fifo_out_valid)
        begin
            bshort_act_reg <= bshort_reg;
        end
    end
end

// Sent word counter
always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        tx_count_reg <= 32'h0000_0000;
    end
    else if (link_tx_valid && link_tx_ready)
    begin
        tx_count_reg <= tx_count_reg + 32'h0000_0001;
    end
end

// ----------------------------------------------------------------
// Receive extraction
// ----------------------------------------------------------------
// Fields and status held until the next control word arrives
always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        rx_valid <= 1'b0;
        rx_chanout <= 30'h0000_0000;
        rx_inband_xon_status <= `XON_RST;
        rx_count_reg <= 32'h0000_0000;
    end
    else
    begin
        rx_valid <= link_rx_valid;
        if (link_rx_valid)
        begin
            rx_chanout[`CB_CHAN_BIT] <=
                link_rx_cw[`CW_CHAN_BIT];
            rx_chanout[`CB_AS2_MSB:`CB_AS2_LSB] <=
                link_rx_cw[`CW_AS2_MSB:`CW_AS2_LSB];
            rx_chanout[`CB_AS1_MSB:`CB_AS1_LSB] <=
                link_rx_cw[`CW_AS1_MSB:`CW_AS1_LSB];
            rx_chanout[`CB_AS0_MSB:`CB_AS0_LSB] <=
                link_rx_cw[`CW_AS0_MSB:`CW_AS0_LSB];
            rx_inband_xon_status <=
                {link_rx_cw[`CW_XON1_BIT],
                 link_rx_cw[`CW_XON0_BIT]};
            rx_count_reg <= rx_count_reg + 32'h0000_0001;
        end
    end
end

endmodule

// ===== la_framer_consts.vh
// Constants for the look-aside control word framer: map, fields, resets
`ifndef LA_FRAMER_CONSTS_VH
`define LA_FRAMER_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets on the Wishbone bus
// ----------------------------------------------------------------
`define OFS_CONFIG 8'h00
`define OFS_STATUS 8'h04
`define OFS_TX_COUNT 8'h08
`define OFS_RX_COUNT 8'h0c

// ----------------------------------------------------------------
// Register fields and reset values
// ----------------------------------------------------------------
`define CFG_BSHORT_LSB 0
`define CFG_BSHORT_MSB 2
`define CFG_BSHORT_RST 3'h0
`define STS_XON_LSB 0
`define STS_XON_MSB 1
`define STS_BADCFG_BIT 2
`define STS_LEVEL_LSB 8
`define STS_LEVEL_MSB 12
`define STS_BUSY_BIT 16
`define XON_RST 2'h3

// ----------------------------------------------------------------
// Burst-short encodings and minimum burst sizes in bytes
// ----------------------------------------------------------------
`define BSHORT_8 3'h0
`define BSHORT_16 3'h1
`define MIN_BYTES_8 8'h08
`define MIN_BYTES_16 8'h10

// ----------------------------------------------------------------
// Control word field positions
// ----------------------------------------------------------------
`define CW_MARK_BIT 63
`define CW_AS0_MSB 56
`define CW_AS0_LSB 42
`define CW_XON1_BIT 41
`define CW_XON0_BIT 40
`define CW_AS1_MSB 38
`define CW_AS1_LSB 33
`define CW_CHAN_BIT 32
`define CW_AS2_MSB 31
`define CW_AS2_LSB 24

// ----------------------------------------------------------------
// Channel bus field positions
// ----------------------------------------------------------------
`define CB_CHAN_BIT 0
`define CB_AS2_MSB 8
`define CB_AS2_LSB 1
`define CB_AS1_MSB 14
`define CB_AS1_LSB 9
`define CB_AS0_MSB 29
`define CB_AS0_LSB 15

`endif

// ===== burst_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module burst_fifo
#(
    parameter WIDTH = 40,
    parameter DEPTH = 16,
    parameter AW = 4
)
(
    input wire sys_clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0] level
);

// ----------------------------------------------------------------
// Storage and pointers
// ----------------------------------------------------------------
reg [WIDTH-1:0] mem_reg [0:DEPTH-1]; // Flop storage
reg [AW-1:0] wr_ptr_reg; // Next slot to fill
reg [AW-1:0] rd_ptr_reg; // Oldest entry
reg [AW:0] count_reg; // Entries held
wire push;
wire pop;

assign in_ready = (count_reg != DEPTH[AW:0]);
assign out_valid = (count_reg != {(AW+1){1'b0}});
assign out_data = mem_reg[rd_ptr_reg];
assign level = count_reg;
assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;

// Storage write; no reset needed on data
always @(posedge sys_clk)
begin
    if (push)
    begin
        mem_reg[wr_ptr_reg] <= in_data;
    end
end

// Pointers and occupancy; depth must be a power of two
always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        wr_ptr_reg <= {AW{1'b0}};
        rd_ptr_reg <= {AW{1'b0}};
        count_reg <= {(AW+1){1'b0}};
    end
    else
    begin
        if (push)
        begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
        if (pop)
        begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
        if (push && !pop)
        begin
            count_reg <= count_reg + 1'b1;
        end
        else if (pop && !push)
        begin
            count_reg <= count_reg - 1'b1;
        end
    end
end

endmodule

// ===== la_framer_assertions.sv
// Checker for the look-aside framer ports, bound to its top module
`timescale 1ns/1ps
module la_framer_assertions
(
    input wire sys_clk,
    input wire rst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire link_tx_valid,
    input wire link_tx_ready,
    input wire [63:0] link_tx_cw,
    input wire [7:0] link_tx_bytes,
    input wire link_rx_valid,
    input wire [63:0] link_rx_cw,
    input wire rx_valid,
    input wire [29:0] rx_chanout,
    input wire [1:0] rx_inband_xon_status
);
    // ------------------------------------------------
    // Single clock domain
    // ------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    property p_rx_pulse;
        link_rx_valid |=> rx_valid;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse)
        else $error("rx_valid missing");
    property p_rx_chan;
        link_rx_valid |=> rx_chanout[0] == $past(link_rx_cw[32]);
    endproperty
    a_rx_chan: assert property (p_rx_chan)
        else $error("rx channel bit wrong");
    property p_rx_f2;
        link_rx_valid |=> rx_chanout[8:1] == $past(link_rx_cw[31:24]);
    endproperty
    a_rx_f2: assert property (p_rx_f2)
        else $error("rx field two wrong");
    property p_rx_f1;
        link_rx_valid |=> rx_chanout[14:9] == $past(link_rx_cw[38:33]);
    endproperty
    a_rx_f1: assert property (p_rx_f1)
        else $error("rx field one wrong");
    property p_rx_f0;
        link_rx_valid |=> rx_chanout[29:15] == $past(link_rx_cw[56:42]);
    endproperty
    a_rx_f0: assert property (p_rx_f0)
        else $error("rx field zero wrong");
    property p_rx_xon;
        link_rx_valid |=> rx_inband_xon_status == $past(link_rx_cw[41:40]);
    endproperty
    a_rx_xon: assert property (p_rx_xon)
        else $error("rx flow status wrong");
    // A stalled word must not change under the link
    property p_tx_hold;
        link_tx_valid && !link_tx_ready |=>
            link_tx_valid && $stable(link_tx_cw) && $stable(link_tx_bytes);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("tx word changed while stalled");
    property p_tx_min;
        link_tx_valid |-> link_tx_bytes >= 8'h08;
    endproperty
    a_tx_min: assert property (p_tx_min)
        else $error("tx burst below minimum");
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus ack not a single pulse");
endmodule

bind la_framer la_framer_assertions chk_u
(
    .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .link_tx_valid(link_tx_valid), .link_tx_ready(link_tx_ready),
    .link_tx_cw(link_tx_cw), .link_tx_bytes(link_tx_bytes),
    .link_rx_valid(link_rx_valid), .link_rx_cw(link_rx_cw),
    .rx_valid(rx_valid), .rx_chanout(rx_chanout),
    .rx_inband_xon_status(rx_inband_xon_status)
);

// ===== link_peer.sv
// Behavioural link peer: stalls transmit words, sends receive words
`timescale 1ns/1ps
module link_peer
(
    input wire sys_clk,
    input wire stall,
    output reg link_tx_ready = 1'b0,
    output reg link_rx_valid = 1'b0,
    output wire [63:0] link_rx_cw
);
    reg [63:0] word_reg = 64'h0; // Word on the line while valid
    reg [63:0] noise_reg = 64'h5a5a; // Changing garbage on the line while valid is low

    // Random back-pressure; a full stall on request
    always @(posedge sys_clk)
    begin
        link_tx_ready <= !stall && ($urandom % 4 != 0);
        noise_reg <= ~noise_reg + 64'h1;
    end
    assign link_rx_cw = link_rx_valid ? word_reg : noise_reg;

    // One word per call, back to back when called in a row
    task send(input [63:0] w);
        begin
            link_rx_valid <= 1'b1;
            word_reg <= w;
            @(posedge sys_clk);
        end
    endtask
    task quiet;
        link_rx_valid <= 1'b0;
    endtask
endmodule

// ===== tb.sv
// Self-checking bench for the look-aside control word framer
`timescale 1ns/1ps
`include "la_framer_consts.vh"
module tb;
    reg sys_clk = 0, rst_n = 0, stall = 0, tx_valid = 0;
    reg wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    reg [7:0] wb_adr_i = 0, tx_burst_bytes = 0, minb = 8'h08;
    reg [3:0] wb_sel_i = 0;
    reg [31:0] wb_dat_i = 0, rd, rnd, rx_exp;
    reg [29:0] tx_chanin = 0;
    reg [1:0] tx_burst_num = 0, xon = 2'h3;
    reg [63:0] cw;
    wire [31:0] wb_dat_o;
    wire [63:0] link_tx_cw, link_rx_cw;
    wire [29:0] rx_chanout;
    wire [7:0] link_tx_bytes;
    wire [1:0] rx_xon;
    wire wb_ack_o, tx_ready, link_tx_valid, link_tx_ready;
    wire link_rx_valid, rx_valid;
    integer mismatches = 0, checks_done = 0, cyc_n = 0, tx_words = 0;
    integer k, n, bs, xi;
    reg [71:0] txq[$]; // Expected {bytes, word} per link word
    reg [31:0] rxq[$]; // Expected {status, channel bus} per rx word

    la_framer dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_chanin(tx_chanin),
        .tx_burst_num(tx_burst_num), .tx_burst_bytes(tx_burst_bytes),
        .tx_inband_xon_status(xon), .link_tx_valid(link_tx_valid),
        .link_tx_ready(link_tx_ready), .link_tx_cw(link_tx_cw),
        .link_tx_bytes(link_tx_bytes), .link_rx_valid(link_rx_valid),
        .link_rx_cw(link_rx_cw), .rx_valid(rx_valid),
        .rx_chanout(rx_chanout), .rx_inband_xon_status(rx_xon));
    link_peer peer_u (.sys_clk(sys_clk), .stall(stall),
        .link_tx_ready(link_tx_ready), .link_rx_valid(link_rx_valid),
        .link_rx_cw(link_rx_cw));

    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------
    // Shared tasks
    // ------------------------------------------------
    task give_verdict;
        begin
            if (mismatches == 0 && checks_done > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input [71:0] got, input [71:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp)
            begin
                mismatches = mismatches + 1;
                $display("BAD %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Classic cycle: hold until ack is sampled, then one idle cycle
    task wb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
        begin
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= w;
            wb_adr_i <= a;
            wb_dat_i <= d;
            wb_sel_i <= 4'hf;
            @(posedge sys_clk);
            while (wb_ack_o !== 1'b1)
                @(posedge sys_clk);
            q = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    // Expected word built from the field layout of the channel bus
    task note_entry(input [29:0] c, input [1:0] nb, input [7:0] len);
        integer b;
        reg [63:0] w;
        begin
            w = 64'h0;
            w[63] = 1'b1;
            w[56:42] = c[29:15];
            w[41:40] = xon;
            w[38:33] = c[14:9];
            w[32] = c[0];
            w[31:24] = c[8:1];
            for (b = 0; b <= nb; b = b + 1)
                txq.push_back({(len < minb) ? minb : len, w});
            tx_words = tx_words + nb + 1;
        end
    endtask
    // Caller lowers tx_valid, so entries may run back to back
    task send_entry(input [1:0] nb);
        reg [7:0] len;
        begin
            rnd = $urandom;
            len = 8'h04 + {4'h0, rnd[31:28]};
            tx_chanin <= rnd[29:0];
            tx_burst_num <= nb;
            tx_burst_bytes <= len;
            tx_valid <= 1'b1;
            @(posedge sys_clk);
            while (tx_ready !== 1'b1)
                @(posedge sys_clk);
            note_entry(rnd[29:0], nb, len);
        end
    endtask
    task drain;
        begin
            n = 0;
            while (txq.size() != 0 && n < 3000)
            begin
                @(posedge sys_clk);
                n = n + 1;
            end
            @(posedge sys_clk);
            chk(txq.size(), 0);
        end
    endtask

    // ------------------------------------------------
    // Output watcher and hang limit
    // ------------------------------------------------
    always @(posedge sys_clk)
    begin
        cyc_n = cyc_n + 1;
        if (rst_n && link_tx_valid && link_tx_ready)
        begin
            chk(txq.size() != 0, 1);
            if (txq.size() != 0)
                chk({link_tx_bytes, link_tx_cw}, txq.pop_front());
        end
        if (rst_n && rx_valid)
        begin
            rx_exp = (rxq.size() != 0) ? rxq.pop_front() : 32'h0;
            chk({rx_xon, rx_chanout}, rx_exp);
        end
        // Hang limit last, so nothing runs after the verdict
        if (cyc_n == 30000)
        begin
            mismatches = mismatches + 1;
            give_verdict;
        end
    end

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial
    begin
        rnd = $urandom(83354);
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        wb(0, `OFS_CONFIG, 0, rd);
        chk(rd, 32'h0);
        wb(0, `OFS_STATUS, 0, rd);
        chk(rd, 32'h3);
        wb(1, 8'h10, 32'hff, rd);
        wb(0, 8'h10, 0, rd);
        chk(rd, 32'h0);
        // Both sizes, every flow status, one to four bursts
        for (bs = 0; bs < 2; bs = bs + 1)
        begin
            wb(1, `OFS_CONFIG, bs, rd);
            wb(0, `OFS_CONFIG, 0, rd);
            chk(rd, bs);
            minb = bs ? `MIN_BYTES_16 : `MIN_BYTES_8;
            for (xi = 0; xi < 4; xi = xi + 1)
            begin
                xon <= xi[1:0];
                for (k = 0; k < 6; k = k + 1)
                    send_entry(k[1:0]);
                tx_valid <= 1'b0;
                drain;
            end
        end
        // Reserved size is refused and flagged
        wb(1, `OFS_CONFIG, 32'h2, rd);
        wb(0, `OFS_CONFIG, 0, rd);
        chk(rd, 32'h1);
        wb(0, `OFS_STATUS, 0, rd);
        chk(rd, 32'h7);
        wb(1, `OFS_STATUS, 32'h4, rd);
        wb(0, `OFS_STATUS, 0, rd);
        chk(rd, 32'h3);
        // Back-to-back receive words with random fields
        for (k = 0; k < 12; k = k + 1)
        begin
            cw = {$urandom, $urandom};
            rxq.push_back({cw[41:40], cw[56:42], cw[38:33], cw[31:24],
                cw[32]});
            peer_u.send(cw);
        end
        peer_u.quiet;
        // Fill the buffer against a stalled link, then drain it
        // One entry waits on the stalled link, sixteen fill the buffer;
        // two bursts in the first keep the serializer busy meanwhile
        stall <= 1'b1;
        for (k = 0; k < 17; k = k + 1)
            send_entry((k == 0) ? 2'h1 : 2'h0);
        tx_valid <= 1'b0;
        @(posedge sys_clk);
        chk(tx_ready, 1'b0);
        wb(0, `OFS_STATUS, 0, rd);
        chk({rd[16], rd[12:8]}, 6'h30);
        stall <= 1'b0;
        drain;
        wb(0, `OFS_TX_COUNT, 0, rd);
        chk(rd, tx_words);
        wb(0, `OFS_RX_COUNT, 0, rd);
        chk(rd, 32'hc);
        chk(rxq.size(), 0);
        give_verdict;
    end
endmodule
